/* design/rom_bank_regs.vh */
// address map, field positions and reset values for the rom bank select and i/o decode block
// assumes a 16-bit processor address bus and an 8-bit data bus
`ifndef ROM_BANK_REGS_VH
`define ROM_BANK_REGS_VH

// i/o sub-decoder window, selected by the incoming i/o line
`define IO_WINDOW_BASE        16'h7800
`define IO_WINDOW_LAST        16'h7fff
// sub-decode on address lines a8..a10
`define IO_SUB_LSB            8
`define IO_SUB_MSB            10
`define IO_SUB_ADAPTER        3'h2
`define IO_SUB_SWITCHES       3'h4
`define IO_SUB_BANK           3'h6

// register offsets
`define REAR_SWITCH_READBACK  16'h7c00
`define ROM_BANK_SELECTION    16'h7e00

// banked rom window 8000..bfff, picked out by a15..a14
`define BANK_WINDOW_BASE      16'h8000
`define BANK_WINDOW_LAST      16'hbfff
`define BANK_WINDOW_TAG       2'h2

// rom_bank_selection fields
`define SEL_HALF_BIT          0
`define SEL_CHIP_LSB          1
`define SEL_CHIP_MSB          3
`define SEL_DEC_EN_BIT        4
`define SEL_RESET             8'h00

// bank geometry
`define BANK_COUNT            16
`define BANK_BYTES            16384
`define ROM_CHIPS             8
`define ROM_ADDR_BITS         15
`define ROM_DATA_BITS         8

// synchroniser depth for pins
`define SYNC_STAGES           2

`endif

/* design/pin_sync.v */
// two-flop synchroniser for a group of pins entering the core_clk domain
// assumes each bit is an independent level; multi-bit groups are sampled while stable
`timescale 1ns/1ns
module pin_sync
#(
    parameter WIDTH      = 1,
    parameter RESET_WORD = 1'b0
)
(
    input  wire             core_clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] synced
);
    reg [WIDTH-1:0] stage1;

    // first stage is read only by the second
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= RESET_WORD;
            synced <= RESET_WORD;
        end
        else
        begin
            stage1 <= pin;
            synced <= stage1;
        end
    end
endmodule // pin_sync

/* design/rom_bank_select_io_decode.v */
// i/o sub-decoder and rom bank switching for the interface board
// assumes the processor bus pins and the phase-2 clock are asynchronous to core_clk;
// all of them are synchronised before use, so outputs lag the bus by a few core_clk cycles
//
// How it works
// R1 - i/o decoder needs i/o select, phase-2 qualified
// R2 - a8-a10 give adapter, switch, latch enables
// R3 - sixteen 16k banks, 256k rom total
// R4 - each 32k rom holds two banks
// R5 - write to 7e00 captures data bus
// R6 - latched d0 drives rom address msb
// R7 - d4 enables decoder, d1-d3 pick chip
// R8 - selected bank appears at 8000-bfff
// R9 - bank holds until software writes again
// R10 - bank n: msb n mod 2, chip n/2
// R11 - chip enable 0 goes to companion board
// R12 - chip enables also drive diagnostic leds
// R13 - read 7c00 returns rear-panel switches
// R14 - adapter selected at 7a00, srq pulled low
// R15 - rom gets 15 address, ce, oe; 8 data
// R16 - ce0 only inside banked window
// R17 - i/o select covers 7800-7fff
// R18 - bank latch write-only, reads harmless
// R19 - decoder disabled keeps all chip enables off
`timescale 1ns/1ns
`include "rom_bank_regs.vh"
module rom_bank_select_io_decode
#(
    parameter CHIPS     = `ROM_CHIPS,
    parameter ADDR_BITS = `ROM_ADDR_BITS,
    parameter DATA_BITS = `ROM_DATA_BITS
)
(
    input  wire                 core_clk,
    input  wire                 reset_n,
    input  wire                 phase2_clk,
    input  wire                 io_select_n,
    input  wire [15:0]          cpu_addr,
    input  wire                 cpu_read,
    input  wire [DATA_BITS-1:0] cpu_data_in,
    output reg  [DATA_BITS-1:0] cpu_data_out,
    output reg                  cpu_data_oe,
    input  wire [7:0]           rear_switches,
    input  wire                 adapter_irq_n,
    output reg                  service_request_out,
    output reg                  service_request_oe,
    output reg                  bus_interface_adapter_n,
    output reg                  switch_buffer_enable_n,
    output reg                  bank_latch_enable_n,
    output reg  [CHIPS-1:0]     rom_chip_enables_n,
    output reg  [ADDR_BITS-1:0] rom_addr,
    output reg                  rom_output_enable_n,
    output reg  [CHIPS-1:0]     diag_led_n
);
    localparam PIN_BITS = 1 + 1 + 16 + 1 + DATA_BITS + 8 + 1;

    wire [PIN_BITS-1:0] pins_raw;
    wire [PIN_BITS-1:0] pins;
    wire                phase2;
    wire                io_sel_n;
    wire [15:0]         addr;
    wire                rd;
    wire [DATA_BITS-1:0] wdata;
    wire [7:0]          switches;
    wire                irq_n;

    reg  [7:0]          rom_bank_selection;
    reg  [7:0]          next_bank;
    reg                 io_active;
    reg  [2:0]          io_sub;
    reg                 bank_window;
    reg  [2:0]          chip_index;
    reg                 decoder_on;
    reg                 next_adapter_n;
    reg                 next_switch_n;
    reg                 next_latch_n;
    reg                 next_oe_n;
    reg                 next_data_oe;
    wire [CHIPS-1:0]    next_ce_n;

    assign pins_raw = {phase2_clk, io_select_n, cpu_addr, cpu_read, cpu_data_in, rear_switches, adapter_irq_n};

    // idle bus reads as: no phase-2, i/o deselected, read, no interrupt
    pin_sync
    #(
        .WIDTH      (PIN_BITS),
        .RESET_WORD ({2'b01, 16'h0000, 1'b1, {DATA_BITS{1'b0}}, 8'h00, 1'b1})
    )
    u_pin_sync
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pin      (pins_raw),
        .synced   (pins)
    );

    assign phase2   = pins[PIN_BITS-1];
    assign io_sel_n = pins[PIN_BITS-2];
    assign addr     = pins[PIN_BITS-3 -: 16];
    assign rd       = pins[PIN_BITS-19];
    assign wdata    = pins[PIN_BITS-20 -: DATA_BITS];
    assign switches = pins[8:1];
    assign irq_n    = pins[0];

    // decode terms
    always @*
    begin
        // i/o line is asserted by the memory board only for 7800-7fff
        io_active   = !io_sel_n && phase2;                                     // R1 R17
        io_sub      = addr[`IO_SUB_MSB:`IO_SUB_LSB];                           // R2
        bank_window = (addr[15:14] == `BANK_WINDOW_TAG) && phase2;             // R8
        chip_index  = rom_bank_selection[`SEL_CHIP_MSB:`SEL_CHIP_LSB];         // R7 R10
        decoder_on  = rom_bank_selection[`SEL_DEC_EN_BIT];                     // R7
    end

    // one select per sub-decode code; the unused codes select nothing
    always @*
    begin
        next_adapter_n = 1'b1;
        next_switch_n  = 1'b1;
        next_latch_n   = 1'b1;
        if (io_active)
        begin
            case (io_sub)
                `IO_SUB_ADAPTER:  next_adapter_n = 1'b0;                       // R2 R14
                `IO_SUB_SWITCHES: next_switch_n  = 1'b0;                       // R2 R13
                `IO_SUB_BANK:     next_latch_n   = 1'b0;                       // R2 R5
                default:          next_latch_n   = 1'b1;
            endcase
        end
    end

    // bank latch: captured only on writes, reads leave it alone
    always @*
    begin
        next_bank = rom_bank_selection;                                        // R9
        if (!next_latch_n && !rd)
            next_bank = wdata;                                                 // R5 R18
    end

    // one-of-eight chip enable decoder, active low
    genvar g;
    generate
        for (g = 0; g < CHIPS; g = g + 1)
        begin : g_ce
            // chip 0 is the companion board rom holding banks 0 and 1
            assign next_ce_n[g] = !(decoder_on && bank_window && ({29'h0, chip_index} == g)); // R7 R10 R11 R16 R19
        end
    endgenerate

    // output enable waits for the decoder, so a disabled bank never fights the bus
    always @*
    begin
        next_oe_n    = !(bank_window && rd && decoder_on);                     // R15 R19
        next_data_oe = !next_switch_n && rd;                                   // R13
    end

    // bank selection survives everything but reset
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rom_bank_selection <= `SEL_RESET;
        end
        else
        begin
            rom_bank_selection <= next_bank;                                   // R5 R9
        end
    end

    // i/o selects
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_interface_adapter_n <= 1'b1;
            switch_buffer_enable_n  <= 1'b1;
            bank_latch_enable_n     <= 1'b1;
        end
        else
        begin
            bus_interface_adapter_n <= next_adapter_n;                         // R2 R14
            switch_buffer_enable_n  <= next_switch_n;                          // R2
            bank_latch_enable_n     <= next_latch_n;                           // R2
        end
    end

    // rom side; the leds are a plain copy of the chip enables, lit only while a rom is selected
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rom_chip_enables_n  <= {CHIPS{1'b1}};
            diag_led_n          <= {CHIPS{1'b1}};
            rom_addr            <= {ADDR_BITS{1'b0}};
            rom_output_enable_n <= 1'b1;
        end
        else
        begin
            rom_chip_enables_n  <= next_ce_n;                                  // R3 R4
            diag_led_n          <= next_ce_n;                                  // R12
            // upper rom line picks even or odd bank; a13..a0 pass through
            rom_addr            <= {rom_bank_selection[`SEL_HALF_BIT], addr[13:0]}; // R6 R15
            rom_output_enable_n <= next_oe_n;                                  // R15 R19
        end
    end

    // switch buffer drives the data bus only on reads
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_data_out <= {DATA_BITS{1'b0}};
            cpu_data_oe  <= 1'b0;
        end
        else
        begin
            cpu_data_out <= switches;                                          // R13
            cpu_data_oe  <= next_data_oe;                                      // R13
        end
    end

    // open drain: srq is only ever pulled low
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            service_request_out <= 1'b0;
            service_request_oe  <= 1'b0;
        end
        else
        begin
            service_request_out <= 1'b0;
            service_request_oe  <= !irq_n;                                     // R14
        end
    end
endmodule // rom_bank_select_io_decode

/* bench/rom_bank_chk.sv */
// assertions on the ports of the rom bank and i/o decode block
// assumes outputs follow their pins three core_clk edges later
`timescale 1ns/1ns
module rom_bank_chk (
    input wire        core_clk, reset_n, phase2_clk, io_select_n, cpu_read, adapter_irq_n,
    input wire [15:0] cpu_addr,
    input wire        cpu_data_oe, service_request_out, service_request_oe, rom_output_enable_n,
    input wire        bus_interface_adapter_n, switch_buffer_enable_n, bank_latch_enable_n,
    input wire [7:0]  rom_chip_enables_n, diag_led_n,
    input wire [14:0] rom_addr
);
    reg  [2:0]  up;
    wire        io  = !io_select_n && phase2_clk;
    wire        ad  = io && cpu_addr[10:8] == 3'h2;
    wire        sw  = io && cpu_addr[10:8] == 3'h4;
    wire        bk  = io && cpu_addr[10:8] == 3'h6;
    wire        rs  = sw && cpu_read;
    wire        win = phase2_clk && cpu_addr[15:14] == 2'h2;
    wire [13:0] lo  = cpu_addr[13:0];
    // $past needs three edges of history out of reset
    always @(posedge core_clk or negedge reset_n)
        if (!reset_n) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_adapter_sel: assert property (up == 3'h7 |-> bus_interface_adapter_n == !$past(ad, 3)) else $error("adapter select");
    a_switch_sel: assert property (up == 3'h7 |-> switch_buffer_enable_n == !$past(sw, 3)) else $error("switch select");
    a_latch_sel: assert property (up == 3'h7 |-> bank_latch_enable_n == !$past(bk, 3)) else $error("latch select");
    a_switch_drive: assert property (up == 3'h7 |-> cpu_data_oe == $past(rs, 3)) else $error("switch drive");
    a_srq_follow: assert property (up == 3'h7 |-> service_request_oe == !$past(adapter_irq_n, 3) && !service_request_out)
        else $error("srq follow");
    a_ce_onehot: assert property ($onehot0(~rom_chip_enables_n)) else $error("chip enables");
    a_led_copy: assert property (diag_led_n == rom_chip_enables_n) else $error("led copy");
    a_rom_low: assert property (up == 3'h7 |-> rom_addr[13:0] == $past(lo, 3)) else $error("rom address");
    a_ce_window: assert property (rom_chip_enables_n != 8'hff |-> $past(win, 3)) else $error("ce window");
    a_oe_read: assert property (!rom_output_enable_n |-> $past(win, 3) && $past(cpu_read, 3) && rom_chip_enables_n != 8'hff)
        else $error("rom oe");
    cover property (!bank_latch_enable_n);
    cover property (!rom_output_enable_n);
    cover property (service_request_oe);
endmodule // rom_bank_chk
bind rom_bank_select_io_decode rom_bank_chk i_rom_bank_chk (.*);

/* bench/bank_rom_model.sv */
// bank rom model: answers with chip index, half bit and low address bits
// assumes one chip enable low at a time; a released bus shows the inverse of its last byte
`timescale 1ns/1ns
module bank_rom_model (
    input  wire        core_clk,
    input  wire [7:0]  rom_chip_enables_n,
    input  wire [14:0] rom_addr,
    input  wire        rom_output_enable_n,
    output wire [7:0]  rom_data
);
    reg  [7:0] last = 8'h00;
    reg  [2:0] idx;
    integer    k;
    wire       sel = !rom_output_enable_n && $onehot(~rom_chip_enables_n);
    always @*
        for (idx = 3'h0, k = 0; k < 8; k++) if (!rom_chip_enables_n[k]) idx = k;
    assign rom_data = sel ? {idx, rom_addr[14], rom_addr[3:0]} : ~last;
    always @(posedge core_clk) if (sel) last <= rom_data;
endmodule // bank_rom_model

/* bench/rom_bank_select_io_decode_bench.sv */
// testbench: bank switching, switch readback and srq through the processor bus pins
// assumes three-edge pin-to-output latency; phase-2 held five cycles of each ten-cycle bus access
`timescale 1ns/1ns
module rom_bank_select_io_decode_bench;
    reg          core_clk = 1'b0, reset_n = 1'b0, phase2_clk = 1'b0, io_select_n = 1'b1;
    reg          cpu_read = 1'b1, adapter_irq_n = 1'b1, poe = 1'b1, pde = 1'b0, psr = 1'b0;
    reg  [15:0]  cpu_addr = 16'h0000;
    reg  [7:0]   cpu_data_in = 8'h00, rear_switches = 8'h00, q_rom[$], q_sw[$], q_srq[$];
    wire [7:0]   cpu_data_out, rom_chip_enables_n, diag_led_n, rom_data;
    wire [14:0]  rom_addr;
    wire         cpu_data_oe, service_request_out, service_request_oe, rom_output_enable_n;
    wire         bus_interface_adapter_n, switch_buffer_enable_n, bank_latch_enable_n;
    integer      n_fail = 0, n_compared = 0, seed = 32'h11883f4b, i, r;
    always #20 core_clk = ~core_clk;
    rom_bank_select_io_decode i_rom_bank_select_io_decode (.*);
    bank_rom_model i_bank_rom_model (.*);
    task complete_run;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task cmp(input string what, input [7:0] e, input [7:0] g);
        begin
            n_compared++;
            if (g !== e) begin n_fail++; $display("unexpected %s expected %h seen %h", what, e, g); end
        end
    endtask
    task check_rom(input [7:0] e);
        cmp("rom_read", e, rom_data);
    endtask
    task check_switch(input [7:0] e);
        cmp("switch_read", e, cpu_data_out);
    endtask
    task check_srq(input [7:0] e);
        cmp("srq_drive", e, {6'h00, service_request_out, service_request_oe});
    endtask
    task bus(input [15:0] a, input rd, input [7:0] d);
        begin
            @(posedge core_clk);
            {io_select_n, cpu_addr, cpu_read, cpu_data_in, phase2_clk} <= {a[15:11] != 5'h0f, a, rd, d, 1'b1};
            repeat (5) @(posedge core_clk);
            {phase2_clk, io_select_n} <= 2'b01;
            repeat (4) @(posedge core_clk);
        end
    endtask
    task bank(input [3:0] n);
        begin
            r = $random(seed);
            bus(16'h7e00, 1'b0, {r[7:5], 1'b1, n});
            q_rom.push_back({n[3:1], n[0], r[3:0]});
            bus({2'h2, r[13:0]}, 1'b1, 8'h00);
        end
    endtask
    // a read nobody expected meets an x note and fails
    always @(negedge core_clk) begin
        if (!rom_output_enable_n && poe) check_rom(q_rom.size() ? q_rom.pop_front() : 8'hxx);
        if (cpu_data_oe && !pde) check_switch(q_sw.size() ? q_sw.pop_front() : 8'hxx);
        if (service_request_oe && !psr) check_srq(q_srq.size() ? q_srq.pop_front() : 8'hxx);
        poe = rom_output_enable_n;
        pde = cpu_data_oe;
        psr = service_request_oe;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(16'h8000, 1'b1, 8'h00);
        for (i = 0; i < 16; i++) bank(i);
        bus(16'h7e00, 1'b1, 8'h00);
        q_rom.push_back(8'hf5);
        bus(16'h8005, 1'b1, 8'h00);
        bus(16'h7e00, 1'b0, 8'h0e);
        bus(16'h8000, 1'b1, 8'h00);
        for (i = 0; i < 3; i++) begin
            @(posedge core_clk) rear_switches <= i * 8'h5a + 8'h81;
            q_sw.push_back(i * 8'h5a + 8'h81);
            bus(16'h7c00 + i[7:0], 1'b1, 8'h00);
        end
        bus(16'h7c00, 1'b0, 8'h33);
        bus(16'h7a00, 1'b1, 8'h00);
        bus(16'h3e00, 1'b1, 8'h00);
        @(posedge core_clk) adapter_irq_n <= 1'b0;
        q_srq.push_back(8'h01);
        repeat (4) @(posedge core_clk);
        @(posedge core_clk) {adapter_irq_n, reset_n} <= 2'b10;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(16'h8000, 1'b1, 8'h00);
        bank(4'h9);
        for (i = 0; i < 20 && q_rom.size() + q_sw.size() + q_srq.size() > 0; i++) @(posedge core_clk);
        if (q_rom.size() + q_sw.size() + q_srq.size() > 0) n_fail++;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        complete_run;
    end
endmodule // rom_bank_select_io_decode_bench
